// file: logic/cid_alu.sv
// result and flag computation of the decoded instruction
module cid_alu
	import cid_pkg::*;
(
	// operation
	input  wire cid_pkg::cid_cls_e   cls,
	// operands
	input  wire logic [15:0]         a,
	input  wire logic [7:0]          b,
	input  wire logic [2:0]          bit_sel,
	input  wire logic                pol,
	input  wire cid_pkg::cid_flags_s fin,
	// results
	output logic [15:0]              res,
	output cid_pkg::cid_flags_s      fout
);
	logic [8:0]  sum;
	logic [4:0]  hsum;
	logic [7:0]  r8;
	logic [7:0]  adj;
	logic        cin;
	logic        cda;

	always_comb begin
		fout = fin;
		res  = a;
		cin  = (cls == CID_ADC) ? fin.c : 1'b0;
		sum  = {1'b0, a[7:0]} + {1'b0, b} + {8'h00, cin};
		hsum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		r8   = a[7:0];
		adj  = 8'h00;
		cda  = fin.c;
		case (cls)
			CID_ADD, CID_ADC: begin
				res    = {8'h00, sum[7:0]};
				fout.c = sum[8];
				fout.h = hsum[4];
				fout.v = (a[7] == b[7]) && (sum[7] != a[7]);
				fout.d = 1'b0;
				fout.z = sum[7:0] == 8'h00;
				fout.s = sum[7];
			end
			CID_AND: begin
				r8 = a[7:0] & b;
				res = {8'h00, r8};
				fout.z = r8 == 8'h00;
				fout.s = r8[7];
				fout.v = 1'b0;
			end
			CID_BITW, CID_BREV: begin
				if (cls == CID_BITW) begin
					r8[bit_sel] = pol;
				end else begin
					r8 = {<<{a[7:0]}};
					fout.c = 1'b0;
				end
				res = {8'h00, r8};
				fout.z = r8 == 8'h00;
				fout.s = r8[7];
				fout.v = 1'b0;
			end
			CID_DA: begin
				if (fin.c || a[7:0] > CID_BCD_MAX) begin
					adj = CID_BCD_HI;
					cda = 1'b1;
				end
				if (fin.h || a[3:0] > CID_BCD_DIG) begin
					adj = adj | CID_BCD_LO;
				end
				r8 = fin.d ? a[7:0] - adj : a[7:0] + adj;
				res = {8'h00, r8};
				fout.c = cda;
				fout.z = r8 == 8'h00;
				fout.s = r8[7];
				fout.v = 1'b0;
			end
			CID_INC, CID_DEC: begin
				r8 = (cls == CID_INC) ? a[7:0] + 8'h01 : a[7:0] - 8'h01;
				res = {8'h00, r8};
				fout.z = r8 == 8'h00;
				fout.s = r8[7];
				fout.v = a[7:0] == ((cls == CID_INC) ? CID_POS_MAX : CID_NEG_MIN);
			end
			CID_INCREMENT_WORD, CID_DECREMENT_WORD: begin
				res = (cls == CID_INCREMENT_WORD) ? a + 16'h0001 : a - 16'h0001;
				fout.z = res == 16'h0000;
				fout.s = res[15];
				fout.v = (cls == CID_INCREMENT_WORD) ? (a == 16'h7fff) : (a == 16'h8000);
			end
			CID_DECREMENT_JUMP_NONZERO: begin
				res = {8'h00, a[7:0] - 8'h01};
			end
			CID_INTERRUPT_RETURN: begin
				fout = cid_flags_s'(b[7:2]);
			end
			default: begin
				res = a;
			end
		endcase
	end

endmodule

// file: logic/cid_cond.sv
// condition code test for conditional jumps
module cid_cond
	import cid_pkg::*;
(
	// condition and flags
	input  wire logic [3:0]          cc,
	input  wire cid_pkg::cid_flags_s fl,
	// result
	output logic                     take
);
	logic t;

	// upper half of the code set is the inverse of the lower half
	always_comb begin
		case (cc[2:0])
			3'd0: t = 1'b0;
			3'd1: t = fl.s ^ fl.v;
			3'd2: t = fl.z | (fl.s ^ fl.v);
			3'd3: t = fl.c | fl.z;
			3'd4: t = fl.v;
			3'd5: t = fl.s;
			3'd6: t = fl.z;
			default: t = fl.c;
		endcase
		take = cc[3] ? ~t : t;
	end

endmodule

// file: logic/cid_decode.sv
// instruction decode, flag effect and cycle count top
module cid_decode
	import cid_pkg::*;
#(
	parameter int unsigned WORD_W = CID_WORD_W
)(
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                reset,
	// instruction in
	input  wire logic                op_valid,
	input  wire logic [7:0]          opcode,
	input  wire cid_pkg::cid_opnd_s  opnd,
	input  wire cid_pkg::cid_flags_s flags_in,
	input  wire logic                wake,
	// decode out
	output cid_pkg::cid_dec_s        dec_r,
	output logic                     dec_valid_r,
	output logic                     illegal_r,
	output logic                     gie_r,
	output logic                     halt_r,
	output logic                     brk_r
);
	import cid_pkg::*;

	if (WORD_W != CID_WORD_W) begin : g_chk
		$error("cid_decode serves only a 16-bit word");
	end

	// ************************************************
	// opcode decode
	// ************************************************
	cid_cls_e    cls;
	logic [2:0]  fetch;
	logic [2:0]  exec;
	cid_flags_s  fwe;
	logic        res_we;
	logic        cond;
	logic [3:0]  hi;
	logic [3:0]  lo;
	logic        in_grid;
	logic        cc_take;
	logic        bit_hit;
	logic [15:0] pc_rel;
	logic [15:0] alu_res;
	cid_flags_s  alu_fl;

	assign hi      = opcode[7:4];
	assign lo      = opcode[3:0];
	assign in_grid = (lo >= CID_COL_LO) && (lo <= CID_COL_HI);

	always_comb begin
		cls    = CID_NONE;
		fetch  = CID_CYC_1;
		exec   = CID_CYC_1;
		fwe    = '0;
		res_we = 1'b0;
		cond   = 1'b0;
		if (in_grid && (hi == CID_ROW_ADD || hi == CID_ROW_ADC)) begin
			cls    = (hi == CID_ROW_ADC) ? CID_ADC : CID_ADD;
			fetch  = (lo < CID_COL_IR + 4'h1) ? CID_CYC_2 : CID_CYC_3;
			exec   = lo[0] ? CID_CYC_4 : CID_CYC_3;
			fwe    = '1;
			res_we = 1'b1;
		end else if (in_grid && hi == CID_ROW_AND) begin
			cls    = CID_AND;
			fetch  = (lo < CID_COL_IR + 4'h1) ? CID_CYC_2 : CID_CYC_3;
			exec   = lo[0] ? CID_CYC_4 : CID_CYC_3;
			fwe    = 6'b011100;
			res_we = 1'b1;
		end else if (lo == CID_COL_DECREMENT_JUMP_NONZERO) begin
			cls    = CID_DECREMENT_JUMP_NONZERO;
			fetch  = CID_CYC_2;
			exec   = CID_CYC_3;
			res_we = 1'b1;
		end else if (lo == CID_COL_JR) begin
			cls   = CID_JR;
			fetch = CID_CYC_2;
			exec  = CID_CYC_2;
			cond  = cc_take;
		end else if (lo == CID_COL_JP) begin
			cls   = CID_JP;
			fetch = CID_CYC_3;
			exec  = CID_CYC_2;
			cond  = cc_take;
		end else if (lo == CID_COL_INC) begin
			cls    = CID_INC;
			fetch  = CID_CYC_1;
			exec   = CID_CYC_2;
			fwe    = 6'b011100;
			res_we = 1'b1;
		end else begin
			case (opcode)
				CID_OP_ADD_EXTENDED_E, CID_OP_ADD_EXTENDED_I, CID_OP_ADD_WITH_CARRY_EXTENDED_E, CID_OP_ADD_WITH_CARRY_EXTENDED_I: begin
					cls    = opcode[4] ? CID_ADC : CID_ADD;
					fetch  = CID_CYC_4;
					exec   = CID_CYC_3;
					fwe    = '1;
					res_we = 1'b1;
				end
				CID_OP_AND_EXTENDED_E, CID_OP_AND_EXTENDED_I: begin
					cls    = CID_AND;
					fetch  = CID_CYC_4;
					exec   = CID_CYC_3;
					fwe    = 6'b011100;
					res_we = 1'b1;
				end
				CID_OP_BITW: begin
					cls    = CID_BITW;
					fetch  = CID_CYC_2;
					exec   = CID_CYC_2;
					fwe    = 6'b011100;
					res_we = 1'b1;
				end
				CID_OP_BRK: begin
					cls = CID_BRK;
				end
				CID_OP_BREV: begin
					cls    = CID_BREV;
					fetch  = CID_CYC_2;
					exec   = CID_CYC_2;
					fwe    = 6'b111100;
					res_we = 1'b1;
				end
				CID_OP_BTJ_R, CID_OP_BTJ_I: begin
					cls   = CID_BTJ;
					fetch = CID_CYC_3;
					exec  = opcode[0] ? CID_CYC_4 : CID_CYC_3;
					cond  = bit_hit;
				end
				CID_OP_DA_D, CID_OP_DA_I: begin
					cls    = CID_DA;
					fetch  = CID_CYC_2;
					exec   = opcode[0] ? CID_CYC_3 : CID_CYC_2;
					fwe    = 6'b111100;
					res_we = 1'b1;
				end
				CID_OP_DEC_D, CID_OP_DEC_I, CID_OP_INC_D, CID_OP_INC_I: begin
					cls    = opcode[4] ? CID_DEC : CID_INC;
					fetch  = CID_CYC_2;
					exec   = opcode[0] ? CID_CYC_3 : CID_CYC_2;
					fwe    = 6'b011100;
					res_we = 1'b1;
				end
				CID_OP_DECREMENT_WORD_D, CID_OP_DECREMENT_WORD_I, CID_OP_INCREMENT_WORD_D, CID_OP_INCREMENT_WORD_I: begin
					cls    = opcode[5] ? CID_INCREMENT_WORD : CID_DECREMENT_WORD;
					fetch  = CID_CYC_2;
					exec   = opcode[0] ? CID_CYC_6 : CID_CYC_5;
					fwe    = 6'b011100;
					res_we = 1'b1;
				end
				CID_OP_DI, CID_OP_EI: begin
					cls  = opcode[4] ? CID_EI : CID_DI;
					exec = CID_CYC_2;
				end
				CID_OP_HALT: begin
					cls  = CID_HALT;
					exec = CID_CYC_2;
				end
				CID_OP_INTERRUPT_RETURN: begin
					cls  = CID_INTERRUPT_RETURN;
					exec = CID_CYC_5;
					fwe  = '1;
					cond = 1'b1;
				end
				CID_OP_JP_IRR: begin
					cls   = CID_JP;
					fetch = CID_CYC_2;
					exec  = CID_CYC_3;
					cond  = 1'b1;
				end
				default: begin
					cls = CID_NONE;
				end
			endcase
		end
	end

	// ************************************************
	// datapath helpers
	// ************************************************
	cid_cond u_cond (
		.cc   (hi),
		.fl   (flags_in),
		.take (cc_take)
	);

	cid_alu u_alu (
		.cls     (cls),
		.a       (opnd.dst),
		.b       (opnd.src),
		.bit_sel (opnd.bit_sel),
		.pol     (opnd.pol),
		.fin     (flags_in),
		.res     (alu_res),
		.fout    (alu_fl)
	);

	assign bit_hit = opnd.src[opnd.bit_sel] == opnd.pol;
	assign pc_rel  = opnd.pc + {{8{opnd.disp[7]}}, opnd.disp};

	// ************************************************
	// registered decode
	// ************************************************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			dec_r       <= '0;
			dec_valid_r <= 1'b0;
			illegal_r   <= 1'b0;
		end else begin
			dec_valid_r <= op_valid;
			illegal_r   <= op_valid && cls == CID_NONE;
			if (op_valid) begin
				dec_r.cls    <= cls;
				dec_r.fetch  <= fetch;
				dec_r.exec   <= exec;
				dec_r.fwe    <= fwe;
				dec_r.flags  <= alu_fl;
				dec_r.result <= alu_res;
				dec_r.res_we <= res_we;
				if (cls == CID_DECREMENT_JUMP_NONZERO) begin
					dec_r.pc_load <= alu_res[7:0] != 8'h00;
				end else begin
					dec_r.pc_load <= cond;
				end
				if (cls == CID_JP || cls == CID_INTERRUPT_RETURN) begin
					dec_r.pc_next <= opnd.dst;
				end else begin
					dec_r.pc_next <= pc_rel;
				end
			end
		end
	end

	// ************************************************
	// global interrupt enable, halt and break
	// ************************************************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			gie_r <= 1'b0;
		end else if (op_valid && cls == CID_DI) begin
			gie_r <= 1'b0;
		end else if (op_valid && (cls == CID_EI || cls == CID_INTERRUPT_RETURN)) begin
			gie_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			halt_r <= 1'b0;
		end else if (op_valid && cls == CID_HALT) begin
			halt_r <= 1'b1;
		end else if (wake) begin
			halt_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			brk_r <= 1'b0;
		end else begin
			brk_r <= op_valid && cls == CID_BRK;
		end
	end

	// ************************************************
	// assertions
	// ************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_op(logic [7:0] code);
		op_valid && opcode == code;
	endsequence

	sequence s_done;
		dec_valid_r && dec_r.fwe == '0;
	endsequence

	a_adc_carry_in: assert property (
		op_valid && opcode == 8'h12 |=> dec_r.result[7:0] ==
			8'($past(opnd.dst[7:0]) + $past(opnd.src) + 8'($past(flags_in.c)))
			&& !dec_r.flags.d)
		else $error("adc result or decimal flag wrong");
	a_add_ext_cyc: assert property (
		op_valid && opcode inside {8'h08, 8'h09, 8'h18, 8'h19}
		|=> dec_r.fetch == 3'd4 && dec_r.exec == 3'd3)
		else $error("extended add cycle counts wrong");
	a_and_flags: assert property (
		op_valid && opcode inside {[8'h52:8'h57]} |=> !dec_r.flags.v
		&& dec_r.flags.c == $past(flags_in.c) && dec_r.flags.h == $past(flags_in.h))
		else $error("and flag effect wrong");
	a_brk_pulse: assert property (
		s_op(8'h00) |=> (brk_r && dec_r.exec == 3'd1) and s_done)
		else $error("break decode wrong");
	a_brev_order: assert property (
		s_op(8'hd5) |=> dec_r.result[0] == $past(opnd.dst[7])
		&& dec_r.result[7] == $past(opnd.dst[0]) && !dec_r.flags.v)
		else $error("bit reverse wrong");
	a_decrement_word_cyc: assert property (
		s_op(8'h81) |=> dec_r.exec == 3'd6 && dec_r.fwe == 6'b011100)
		else $error("word decrement cycles wrong");
	a_di_clears_gie: assert property (
		s_op(8'h8f) ##1 !op_valid |-> !gie_r ##1 !gie_r)
		else $error("interrupt disable did not hold");
	a_ei_sets_gie: assert property (
		s_op(8'h9f) |=> gie_r && dec_r.exec == 3'd2)
		else $error("interrupt enable failed");
	a_decrement_jump_nonzero_branch: assert property (
		op_valid && lo == 4'ha |=> s_done
		and (dec_r.pc_load == (dec_r.result[7:0] != 8'h00)))
		else $error("decrement jump decision wrong");
	a_interrupt_return_seq: assert property (
		s_op(8'hbf) |=> gie_r && dec_r.pc_load && dec_r.exec == 3'd5
		&& dec_r.flags == $past(opnd.src[7:2]))
		else $error("interrupt return wrong");
	a_jr_always: assert property (
		s_op(8'h8b) |=> dec_r.pc_load && dec_r.fetch == 3'd2)
		else $error("unconditional relative jump not taken");

endmodule

// file: logic/cid_pkg.sv
// shared constants and carriers of the instruction decode subset
package cid_pkg;

	localparam int unsigned CID_DATA_W = 8;
	localparam int unsigned CID_WORD_W = 16;

	// ********************************
	// single opcodes
	// ********************************
	localparam logic [7:0] CID_OP_BRK    = 8'h00;
	localparam logic [7:0] CID_OP_ADD_EXTENDED_E = 8'h08;
	localparam logic [7:0] CID_OP_ADD_EXTENDED_I = 8'h09;
	localparam logic [7:0] CID_OP_ADD_WITH_CARRY_EXTENDED_E = 8'h18;
	localparam logic [7:0] CID_OP_ADD_WITH_CARRY_EXTENDED_I = 8'h19;
	localparam logic [7:0] CID_OP_AND_EXTENDED_E = 8'h58;
	localparam logic [7:0] CID_OP_AND_EXTENDED_I = 8'h59;
	localparam logic [7:0] CID_OP_DA_D   = 8'h40;
	localparam logic [7:0] CID_OP_DA_I   = 8'h41;
	localparam logic [7:0] CID_OP_DEC_D  = 8'h30;
	localparam logic [7:0] CID_OP_DEC_I  = 8'h31;
	localparam logic [7:0] CID_OP_INC_D  = 8'h20;
	localparam logic [7:0] CID_OP_INC_I  = 8'h21;
	localparam logic [7:0] CID_OP_DECREMENT_WORD_D = 8'h80;
	localparam logic [7:0] CID_OP_DECREMENT_WORD_I = 8'h81;
	localparam logic [7:0] CID_OP_INCREMENT_WORD_D = 8'ha0;
	localparam logic [7:0] CID_OP_INCREMENT_WORD_I = 8'ha1;
	localparam logic [7:0] CID_OP_DI     = 8'h8f;
	localparam logic [7:0] CID_OP_EI     = 8'h9f;
	localparam logic [7:0] CID_OP_HALT   = 8'h7f;
	localparam logic [7:0] CID_OP_INTERRUPT_RETURN   = 8'hbf;
	localparam logic [7:0] CID_OP_BITW   = 8'he2;
	localparam logic [7:0] CID_OP_BREV   = 8'hd5;
	localparam logic [7:0] CID_OP_BTJ_R  = 8'hf6;
	localparam logic [7:0] CID_OP_BTJ_I  = 8'hf7;
	localparam logic [7:0] CID_OP_JP_IRR = 8'hc4;

	// ********************************
	// rows and columns of the opcode grid
	// ********************************
	localparam logic [3:0] CID_ROW_ADD  = 4'h0;
	localparam logic [3:0] CID_ROW_ADC  = 4'h1;
	localparam logic [3:0] CID_ROW_AND  = 4'h5;
	localparam logic [3:0] CID_COL_LO   = 4'h2;
	localparam logic [3:0] CID_COL_HI   = 4'h7;
	localparam logic [3:0] CID_COL_DECREMENT_JUMP_NONZERO = 4'ha;
	localparam logic [3:0] CID_COL_JR   = 4'hb;
	localparam logic [3:0] CID_COL_JP   = 4'hd;
	localparam logic [3:0] CID_COL_INC  = 4'he;
	localparam logic [3:0] CID_COL_IR   = 4'h3;

	// ********************************
	// cycle counts
	// ********************************
	localparam logic [2:0] CID_CYC_1 = 3'd1;
	localparam logic [2:0] CID_CYC_2 = 3'd2;
	localparam logic [2:0] CID_CYC_3 = 3'd3;
	localparam logic [2:0] CID_CYC_4 = 3'd4;
	localparam logic [2:0] CID_CYC_5 = 3'd5;
	localparam logic [2:0] CID_CYC_6 = 3'd6;

	// ********************************
	// alu constants
	// ********************************
	localparam logic [7:0] CID_BCD_LO  = 8'h06;
	localparam logic [7:0] CID_BCD_HI  = 8'h60;
	localparam logic [7:0] CID_BCD_MAX = 8'h99;
	localparam logic [3:0] CID_BCD_DIG = 4'h9;
	localparam logic [7:0] CID_POS_MAX = 8'h7f;
	localparam logic [7:0] CID_NEG_MIN = 8'h80;

	typedef enum logic [4:0] {
		CID_NONE, CID_ADD, CID_ADC, CID_AND, CID_BITW, CID_BRK, CID_BREV,
		CID_BTJ, CID_DA, CID_DEC, CID_DECREMENT_WORD, CID_DI, CID_EI, CID_DECREMENT_JUMP_NONZERO,
		CID_HALT, CID_INC, CID_INCREMENT_WORD, CID_INTERRUPT_RETURN, CID_JP, CID_JR
	} cid_cls_e;

	// order matches the flags byte bits 7..2
	typedef struct packed {
		logic c;
		logic z;
		logic s;
		logic v;
		logic d;
		logic h;
	} cid_flags_s;

	typedef struct packed {
		logic [15:0] dst;
		logic [7:0]  src;
		logic [2:0]  bit_sel;
		logic        pol;
		logic [7:0]  disp;
		logic [15:0] pc;
	} cid_opnd_s;

	typedef struct packed {
		cid_cls_e    cls;
		logic [2:0]  fetch;
		logic [2:0]  exec;
		cid_flags_s  fwe;
		cid_flags_s  flags;
		logic [15:0] result;
		logic        res_we;
		logic        pc_load;
		logic [15:0] pc_next;
	} cid_dec_s;

endpackage

// file: verif/tb.sv
// self-checking bench of the instruction decode subset
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cid_pkg::*;

	// ********************************
	// stimulus and observed signals
	// ********************************
	logic       clk_sys;
	logic       reset;
	logic       op_valid;
	logic [7:0] opcode;
	cid_opnd_s  opnd;
	cid_flags_s flags_in;
	logic       wake;
	cid_dec_s   dec_r;
	logic       dec_valid_r;
	logic       illegal_r;
	logic       gie_r;
	logic       halt_r;
	logic       brk_r;
	int         n_mismatch;
	int         checks;

	cid_decode #(.WORD_W(16)) i_cid_decode (
		.clk_sys     (clk_sys),
		.reset       (reset),
		.op_valid    (op_valid),
		.opcode      (opcode),
		.opnd        (opnd),
		.flags_in    (flags_in),
		.wake        (wake),
		.dec_r       (dec_r),
		.dec_valid_r (dec_valid_r),
		.illegal_r   (illegal_r),
		.gie_r       (gie_r),
		.halt_r      (halt_r),
		.brk_r       (brk_r)
	);

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// ********************************
	// compare and drive helpers
	// ********************************
	task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_flag(input logic [5:0] got, input logic [5:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// one instruction, answer looked at 1 ns after the taking edge
	task automatic issue(input logic [7:0] op, input logic [15:0] dst = 16'h0,
			input logic [7:0] src = 8'h0, input logic [5:0] fl = 6'h0,
			input logic [2:0] bs = 3'h0, input logic pl = 1'b0, input logic [7:0] ds = 8'h0);
		@(posedge clk_sys);
		#1;
		op_valid = 1'b1;
		opcode = op;
		opnd = '{dst, src, bs, pl, ds, 16'h1000};
		flags_in = fl;
		@(posedge clk_sys);
		#1;
		op_valid = 1'b0;
		cmp_val(16'(dec_valid_r), 16'h1);
	endtask

	task automatic ck(input logic [15:0] r, input logic [5:0] f, input logic w = 1'b0);
		cmp_val(w ? dec_r.result : {8'h00, dec_r.result[7:0]}, r);
		cmp_flag(dec_r.flags, f);
		cmp_val(16'(dec_r.res_we), 16'h1);
	endtask

	task automatic cj(input logic l, input logic [15:0] n, input logic [5:0] f);
		cmp_val(16'(dec_r.pc_load), 16'(l));
		if (l) begin
			cmp_val(dec_r.pc_next, n);
		end
		cmp_flag(dec_r.flags, f);
	endtask

	task automatic row(input logic [7:0] op, input cid_cls_e c, input logic [2:0] f,
			input logic [2:0] e);
		issue(op);
		cmp_val(16'(dec_r.cls), 16'(c));
		cmp_val(16'(dec_r.fetch), 16'(f));
		cmp_val(16'(dec_r.exec), 16'(e));
		cmp_val(16'(illegal_r), 16'(c == CID_NONE));
	endtask

	// ********************************
	// scenarios
	// ********************************
	task automatic t_reset();
		cmp_val(16'({dec_valid_r, illegal_r, gie_r, halt_r, brk_r, dec_r.pc_load}), 16'h0);
		cmp_val(dec_r.result, 16'h0);
	endtask

	task automatic t_arith();
		issue(8'h02, 16'h007f, 8'h01, 6'h20);
		ck(16'h0080, 6'h0d);
		cmp_flag(dec_r.fwe, 6'h3f);
		issue(8'h12, 16'h00ff, 8'h00, 6'h22);
		ck(16'h0000, 6'h31);
		issue(8'h08, 16'h0001, 8'h01, 6'h20);
		ck(16'h0002, 6'h00);
		issue(8'h19, 16'h0001, 8'h01, 6'h20);
		ck(16'h0003, 6'h00);
	endtask

	task automatic t_logic();
		issue(8'h52, 16'h00f0, 8'h0f, 6'h27);
		ck(16'h0000, 6'h33);
		cmp_flag(dec_r.fwe, 6'h1c);
		issue(8'h59, 16'h00f0, 8'hc0, 6'h27);
		ck(16'h00c0, 6'h2b);
		issue(8'he2, 16'h0000, 8'h00, 6'h04, 3'h7, 1'b1);
		ck(16'h0080, 6'h08);
		issue(8'he2, 16'h0080, 8'h00, 6'h00, 3'h7, 1'b0);
		ck(16'h0000, 6'h10);
		issue(8'hd5, 16'h0001, 8'h00, 6'h20);
		ck(16'h0080, 6'h08);
		issue(8'hd5, 16'h000c);
		ck(16'h0030, 6'h00);
		issue(8'h40, 16'h009a);
		ck(16'h0000, 6'h30);
	endtask

	task automatic t_count();
		issue(8'h30, 16'h0080, 8'h00, 6'h20);
		ck(16'h007f, 6'h24);
		issue(8'h20, 16'h007f);
		ck(16'h0080, 6'h0c);
		issue(8'h3e, 16'h00ff);
		ck(16'h0000, 6'h10);
		issue(8'h80, 16'h0000);
		ck(16'hffff, 6'h08, 1'b1);
		issue(8'ha1, 16'h7fff);
		ck(16'h8000, 6'h0c, 1'b1);
		issue(8'h1a, 16'h0001, 8'h00, 6'h3f, 3'h0, 1'b0, 8'h05);
		ck(16'h0000, 6'h3f);
		cj(1'b0, 16'h0, 6'h3f);
		issue(8'h1a, 16'h0002, 8'h00, 6'h3f, 3'h0, 1'b0, 8'h05);
		ck(16'h0001, 6'h3f);
		cj(1'b1, 16'h1005, 6'h3f);
	endtask

	task automatic t_ctrl();
		issue(8'h00, 16'h0, 8'h0, 6'h15);
		cmp_val({15'h0, brk_r}, 16'h1);
		cmp_flag(dec_r.flags, 6'h15);
		@(posedge clk_sys);
		#1;
		cmp_val({15'h0, brk_r}, 16'h0);
		issue(8'h9f, 16'h0, 8'h0, 6'h2a);
		cmp_val({15'h0, gie_r}, 16'h1);
		cmp_flag(dec_r.flags, 6'h2a);
		issue(8'h8f, 16'h0, 8'h0, 6'h2a);
		cmp_val({15'h0, gie_r}, 16'h0);
		issue(8'hbf, 16'h1234, 8'h54);
		cj(1'b1, 16'h1234, 6'h15);
		cmp_val({15'h0, gie_r}, 16'h1);
		issue(8'h7f, 16'h0, 8'h0, 6'h09);
		cmp_val({15'h0, halt_r}, 16'h1);
		cmp_flag(dec_r.flags, 6'h09);
		repeat (3) @(posedge clk_sys);
		#1;
		cmp_val({15'h0, halt_r}, 16'h1);
		wake = 1'b1;
		@(posedge clk_sys);
		#1;
		wake = 1'b0;
		cmp_val({15'h0, halt_r}, 16'h0);
	endtask

	task automatic t_jump();
		issue(8'hf6, 16'h0, 8'h08, 6'h11, 3'h3, 1'b1, 8'hfe);
		cj(1'b1, 16'h0ffe, 6'h11);
		issue(8'hf6, 16'h0, 8'h08, 6'h11, 3'h3, 1'b0, 8'hfe);
		cj(1'b0, 16'h0, 6'h11);
		issue(8'hf7, 16'h0, 8'h00, 6'h00, 3'h0, 1'b0, 8'h10);
		cj(1'b1, 16'h1010, 6'h00);
		issue(8'h8d, 16'h2345);
		cj(1'b1, 16'h2345, 6'h00);
		issue(8'h0d, 16'h2345);
		cj(1'b0, 16'h0, 6'h00);
		issue(8'h6d, 16'h2345, 8'h00, 6'h10);
		cj(1'b1, 16'h2345, 6'h10);
		issue(8'hed, 16'h2345, 8'h00, 6'h10);
		cj(1'b0, 16'h0, 6'h10);
		issue(8'hc4, 16'h4000);
		cj(1'b1, 16'h4000, 6'h00);
		issue(8'h8b, 16'h0, 8'h00, 6'h00, 3'h0, 1'b0, 8'h7f);
		cj(1'b1, 16'h107f, 6'h00);
		issue(8'h0b, 16'h0, 8'h00, 6'h00, 3'h0, 1'b0, 8'h7f);
		cj(1'b0, 16'h0, 6'h00);
		issue(8'h7b, 16'h0, 8'h00, 6'h20, 3'h0, 1'b0, 8'h80);
		cj(1'b1, 16'h0f80, 6'h20);
		issue(8'h1b, 16'h0, 8'h00, 6'h08, 3'h0, 1'b0, 8'h02);
		cj(1'b1, 16'h1002, 6'h08);
		issue(8'h2d, 16'h2345, 8'h00, 6'h04);
		cj(1'b1, 16'h2345, 6'h04);
		issue(8'h3b, 16'h0, 8'h00, 6'h0c, 3'h0, 1'b0, 8'h02);
		cj(1'b0, 16'h0, 6'h0c);
		issue(8'h4d, 16'h2345, 8'h00, 6'h04);
		cj(1'b1, 16'h2345, 6'h04);
		issue(8'h5b, 16'h0, 8'h00, 6'h08, 3'h0, 1'b0, 8'h02);
		cj(1'b1, 16'h1002, 6'h08);
		issue(8'h9b, 16'h0, 8'h00, 6'h0c, 3'h0, 1'b0, 8'h02);
		cj(1'b1, 16'h1002, 6'h0c);
	endtask

	task automatic t_table();
		row(8'h13, CID_ADC, 2, 4);
		row(8'h17, CID_ADC, 3, 4);
		row(8'h18, CID_ADC, 4, 3);
		row(8'h19, CID_ADC, 4, 3);
		row(8'h02, CID_ADD, 2, 3);
		row(8'h07, CID_ADD, 3, 4);
		row(8'h08, CID_ADD, 4, 3);
		row(8'h09, CID_ADD, 4, 3);
		row(8'h52, CID_AND, 2, 3);
		row(8'h57, CID_AND, 3, 4);
		row(8'h58, CID_AND, 4, 3);
		row(8'he2, CID_BITW, 2, 2);
		row(8'h00, CID_BRK, 1, 1);
		row(8'hd5, CID_BREV, 2, 2);
		row(8'hf7, CID_BTJ, 3, 4);
		row(8'h41, CID_DA, 2, 3);
		row(8'h31, CID_DEC, 2, 3);
		row(8'h80, CID_DECREMENT_WORD, 2, 5);
		row(8'h81, CID_DECREMENT_WORD, 2, 6);
		row(8'h8f, CID_DI, 1, 2);
		row(8'h9f, CID_EI, 1, 2);
		row(8'hfa, CID_DECREMENT_JUMP_NONZERO, 2, 3);
		row(8'h7f, CID_HALT, 1, 2);
		row(8'h21, CID_INC, 2, 3);
		row(8'hfe, CID_INC, 1, 2);
		row(8'ha0, CID_INCREMENT_WORD, 2, 5);
		row(8'ha1, CID_INCREMENT_WORD, 2, 6);
		row(8'hbf, CID_INTERRUPT_RETURN, 1, 5);
		row(8'h8d, CID_JP, 3, 2);
		row(8'hc4, CID_JP, 2, 3);
		row(8'hfd, CID_JP, 3, 2);
		row(8'hfb, CID_JR, 2, 2);
		row(8'h01, CID_NONE, 1, 1);
	endtask

	initial begin
		n_mismatch = 0;
		checks = 0;
		reset = 1'b1;
		op_valid = 1'b0;
		opcode = 8'h00;
		opnd = '0;
		flags_in = '0;
		wake = 1'b0;
		repeat (12) @(posedge clk_sys);
		#1;
		t_reset();
		reset = 1'b0;
		@(posedge clk_sys);
		#1;
		t_reset();
		t_arith();
		t_logic();
		t_count();
		t_ctrl();
		t_jump();
		t_table();
		report_and_stop();
	end
endmodule
